// *** rtl/liu_cfg_map.svh ***
// Register offsets, field positions and reset values of the configuration bank
`ifndef LIU_CFG_MAP_SVH
`define LIU_CFG_MAP_SVH
`define ADDR_MONITOR 8'h0b
`define ADDR_DLB 8'h0c
`define ADDR_CRIT 8'h0d
`define ADDR_AAO 8'h0e
`define ADDR_GC 8'h0f
`define ADDR_TSEL 8'h10
`define ADDR_TMPL 8'h11
`define MASK_MONITOR 8'h0f
`define MASK_GC 8'hfb
`define MASK_TSEL 8'h07
`define MASK_TMPL 8'hcf
`define RST_BYTE 8'h00
`define GC_RX_INTERNAL 7
`define GC_ALARM 6
`define GC_PROT 5
`define GC_CODE 4
`define GC_DEPTH 3
`define GC_POS 1
`define GC_ENABLE 0
`define MON_TX_BIT 3
`define MON_OFF 3'h0
`define TMPL_MATCH_OFF 7
`define TMPL_IMP 3
`define TMPL_E1 3'h0
`define ALL_CHANNELS 8'hff
`define MON_FIELD 3:0
`define MON_LINE 2:0
`define TSEL_FIELD 2:0
`define TMPL_MODE 2:0
`endif

// *** rtl/liu_cfg_pkg.sv ***
// Types shared by the configuration bank and its bench
package liu_cfg_pkg;
  typedef enum logic [1:0] {CRIT_G775, CRIT_ETS, CRIT_T1231} crit_t;
endpackage

// *** rtl/liu_chan_path.sv ***
// One channel: pin synchroniser, loopback steering and all-ones generator
`timescale 1ns/1ps
module liu_chan_path
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Controls
  input wire logic loop_digital,
  input wire logic loop_dual,
  input wire logic all_ones,
  // System-side transmit rails (pins)
  input wire logic tx_positive_rail,
  input wire logic tx_negative_rail,
  // Receive decoder output
  input wire logic dec_pos,
  input wire logic dec_neg,
  // Outputs
  output logic rx_positive_rail,
  output logic rx_negative_rail,
  output logic line_pos,
  output logic line_neg
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic phase;
    logic [1:0] rx;
    logic [1:0] line;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.s1 = {tx_positive_rail, tx_negative_rail};
    next_st.s2 = st.s1;
    // Looped data re-enters the decoder in place of line data
    next_st.rx = (loop_digital || loop_dual) ? st.s2 : {dec_pos, dec_neg}; // RQ2 RQ4
    if (loop_dual)
    begin
      next_st.line = {dec_pos, dec_neg}; // RQ4
    end
    else
    begin
      next_st.line = st.s2;
    end
    // Marks alternate so the all-ones stream stays balanced
    if (all_ones)
    begin
      next_st.phase = ~st.phase;
      next_st.line = {~st.phase, st.phase}; // RQ6
    end
    if (srst)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  assign rx_positive_rail = st.rx[1];
  assign rx_negative_rail = st.rx[0];
  assign line_pos = st.line[1];
  assign line_neg = st.line[0];
endmodule // liu_chan_path

// *** rtl/liu_cfg_regs.sv ***
// Global configuration registers of the eight-channel line interface
//
// Overview of operation
// RQ1: Four-bit monitor field picks receive or transmit line 2-8; lowest code disables.
// RQ2: Loopback bit sends encoded transmit rails back through decoder to receive rails.
// RQ3: In loopback the jitter attenuator may sit in transmit or receive path.
// RQ4: Digital plus remote loopback on a channel gives dual loopback.
// RQ5: Criteria bit picks ETS or G.775 in E1; T1/J1 always T1.231.
// RQ6: Auto all-ones bit sends all ones on loss of signal, master-clock timed.
// RQ7: Global receive mode bit set selects internal termination, clear external.
// RQ8: External mode without match-off trims internally except E1 120 ohm.
// RQ9: Global alarm-on-loss bit forces AIS on loss for all channels.
// RQ10: Global protection-disable bit disables short protection on all transmitters.
// RQ11: Global code bit forces AMI on all channels.
// RQ12: Global depth bit forces 128-bit attenuator FIFO on all channels.
// RQ13: Global position bit forces attenuator into receive path of all channels.
// RQ14: Global enable bit enables attenuator on all channels.
// RQ15: Three-bit selector chooses which channel template register accesses reach.
// RQ16: Receiver 1 monitors, so only channels 2-8 can be monitored.
// RQ17: Selector code 000 is channel 1 up to 111 channel 8.
// RQ18: Reads return last written value; reserved bits read zero.
`timescale 1ns/1ps
`include "liu_cfg_map.svh"
module liu_cfg_regs
#(
  // Set for the 120 ohm default variant
  parameter bit E1_DEFAULT_120 = 1'b1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host port
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // Per-channel settings held in other banks
  input wire logic [7:0] remote_loopback_enable,
  input wire logic [7:0] per_channel_alarm_on_loss,
  input wire logic [7:0] per_channel_protection_disable,
  input wire logic [7:0] per_channel_code_select,
  input wire logic [7:0] per_channel_attenuator_depth,
  input wire logic [7:0] per_channel_attenuator_position,
  input wire logic [7:0] per_channel_attenuator_enable,
  input wire logic [7:0] loss_detected,
  // Channel datapath
  input wire logic [7:0] tx_positive_rail,
  input wire logic [7:0] tx_negative_rail,
  input wire logic [7:0] dec_pos,
  input wire logic [7:0] dec_neg,
  output logic [7:0] rx_positive_rail,
  output logic [7:0] rx_negative_rail,
  output logic [7:0] line_pos,
  output logic [7:0] line_neg,
  // Effective per-channel controls
  output logic [7:0] loop_digital,
  output logic [7:0] loop_dual,
  output logic [7:0] all_ones,
  output liu_cfg_pkg::crit_t [7:0] criteria,
  output logic [7:0] alarm_on_loss,
  output logic [7:0] protection_disable,
  output logic [7:0] ami_select,
  output logic [7:0] depth_128,
  output logic [7:0] attenuator_in_rx,
  output logic [7:0] attenuator_enable,
  output logic [7:0] rx_trim_enable,
  output logic [7:0] [7:0] template_select,
  // Global controls
  output logic receive_termination_internal,
  // Nonintrusive monitor
  output logic monitor_enable,
  output logic monitor_tx,
  output logic [2:0] monitor_channel
);
  typedef struct packed {
    logic [3:0] monitor_line_select;
    logic [7:0] digital_loopback_enable;
    logic [7:0] loss_alarm_criteria_select;
    logic [7:0] auto_all_ones_on_loss;
    logic [7:0] global_configuration;
    logic [2:0] template_channel_select;
    logic [7:0] [7:0] tmpl;
    logic [7:0] rdata;
    logic [7:0] dlb_eff;
    logic [7:0] dual_eff;
    logic [7:0] ones_eff;
    liu_cfg_pkg::crit_t [7:0] crit_eff;
    logic [7:0] alarm_eff;
    logic [7:0] prot_eff;
    logic [7:0] ami_eff;
    logic [7:0] depth_eff;
    logic [7:0] pos_eff;
    logic [7:0] en_eff;
    logic [7:0] trim_eff;
    logic rx_int;
    logic mon_en;
    logic mon_tx;
    logic [2:0] mon_ch;
  } cfg_state_t;

  cfg_state_t st;
  cfg_state_t next_st;

  // --------------------------------------------------------------
  // Register access and effective controls
  // --------------------------------------------------------------
  always_comb
  begin
    logic [7:0] rd;
    logic e1;
    logic e1_120;
    rd = `RST_BYTE;
    e1 = 1'b0;
    e1_120 = 1'b0;
    next_st = st;

    // --------------------------------------------------------------
    // Host writes
    // --------------------------------------------------------------
    if (host_wr)
    begin
      unique case (host_addr)
        `ADDR_MONITOR:
        begin
          next_st.monitor_line_select = host_wdata[`MON_FIELD];
        end
        `ADDR_DLB:
        begin
          next_st.digital_loopback_enable = host_wdata;
        end
        `ADDR_CRIT:
        begin
          next_st.loss_alarm_criteria_select = host_wdata;
        end
        `ADDR_AAO:
        begin
          next_st.auto_all_ones_on_loss = host_wdata;
        end
        `ADDR_GC:
        begin
          next_st.global_configuration = host_wdata & `MASK_GC; // RQ18
        end
        `ADDR_TSEL:
        begin
          next_st.template_channel_select = host_wdata[`TSEL_FIELD];
        end
        // Template write lands on the channel named by the selector
        `ADDR_TMPL:
        begin
          next_st.tmpl[st.template_channel_select] = host_wdata & `MASK_TMPL; // RQ15 RQ17
        end
        // Unmapped offsets are ignored
        default:
        begin
          next_st.rdata = st.rdata;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Host reads
    // --------------------------------------------------------------
    unique case (host_addr)
      `ADDR_MONITOR:
      begin
        rd = 8'(st.monitor_line_select) & `MASK_MONITOR;
      end
      `ADDR_DLB:
      begin
        rd = st.digital_loopback_enable;
      end
      `ADDR_CRIT:
      begin
        rd = st.loss_alarm_criteria_select;
      end
      `ADDR_AAO:
      begin
        rd = st.auto_all_ones_on_loss;
      end
      `ADDR_GC:
      begin
        rd = st.global_configuration;
      end
      `ADDR_TSEL:
      begin
        rd = 8'(st.template_channel_select) & `MASK_TSEL;
      end
      `ADDR_TMPL:
      begin
        rd = st.tmpl[st.template_channel_select]; // RQ15
      end
      default:
      begin
        rd = `RST_BYTE;
      end
    endcase
    // Read data holds between reads
    if (host_rd)
    begin
      next_st.rdata = rd; // RQ18
    end

    // --------------------------------------------------------------
    // Monitor selection
    // --------------------------------------------------------------
    // Receiver 1 is the monitor, so line code n means channel n+1
    next_st.mon_tx = st.monitor_line_select[`MON_TX_BIT]; // RQ1
    next_st.mon_ch = st.monitor_line_select[`MON_LINE]; // RQ16
    next_st.mon_en = st.monitor_line_select[`MON_LINE] != `MON_OFF; // RQ1

    // --------------------------------------------------------------
    // Per-channel controls
    // --------------------------------------------------------------
    next_st.rx_int = st.global_configuration[`GC_RX_INTERNAL]; // RQ7
    for (int n = 0; n < 8; n++)
    begin
      e1 = st.tmpl[n][`TMPL_MODE] == `TMPL_E1;
      e1_120 = e1 && (st.tmpl[n][`TMPL_IMP] != E1_DEFAULT_120);
      next_st.dual_eff[n] = st.digital_loopback_enable[n] && remote_loopback_enable[n]; // RQ4
      next_st.dlb_eff[n] = st.digital_loopback_enable[n] && !remote_loopback_enable[n]; // RQ2 RQ4
      next_st.ones_eff[n] = st.auto_all_ones_on_loss[n] && loss_detected[n]; // RQ6
      if (!e1)
      begin
        next_st.crit_eff[n] = liu_cfg_pkg::CRIT_T1231; // RQ5
      end
      else if (st.loss_alarm_criteria_select[n])
      begin
        next_st.crit_eff[n] = liu_cfg_pkg::CRIT_ETS; // RQ5
      end
      else
      begin
        next_st.crit_eff[n] = liu_cfg_pkg::CRIT_G775; // RQ5
      end
      // Trim only matters when the external resistor sets the impedance
      next_st.trim_eff[n] = !st.global_configuration[`GC_RX_INTERNAL]
        && !st.tmpl[n][`TMPL_MATCH_OFF] && !e1_120; // RQ8
    end

    // --------------------------------------------------------------
    // Global overrides
    // --------------------------------------------------------------
    // A set global bit wins for every channel; a clear one defers to the bank
    if (st.global_configuration[`GC_ALARM])
    begin
      next_st.alarm_eff = `ALL_CHANNELS; // RQ9
    end
    else
    begin
      next_st.alarm_eff = per_channel_alarm_on_loss; // RQ9
    end
    if (st.global_configuration[`GC_PROT])
    begin
      next_st.prot_eff = `ALL_CHANNELS; // RQ10
    end
    else
    begin
      next_st.prot_eff = per_channel_protection_disable; // RQ10
    end
    if (st.global_configuration[`GC_CODE])
    begin
      next_st.ami_eff = `ALL_CHANNELS; // RQ11
    end
    else
    begin
      next_st.ami_eff = per_channel_code_select; // RQ11
    end
    if (st.global_configuration[`GC_DEPTH])
    begin
      next_st.depth_eff = `ALL_CHANNELS; // RQ12
    end
    else
    begin
      next_st.depth_eff = per_channel_attenuator_depth; // RQ12
    end
    // Position applies in loopback too, giving either path
    if (st.global_configuration[`GC_POS])
    begin
      next_st.pos_eff = `ALL_CHANNELS; // RQ13 RQ3
    end
    else
    begin
      next_st.pos_eff = per_channel_attenuator_position; // RQ13 RQ3
    end
    if (st.global_configuration[`GC_ENABLE])
    begin
      next_st.en_eff = `ALL_CHANNELS; // RQ14
    end
    else
    begin
      next_st.en_eff = per_channel_attenuator_enable; // RQ14
    end

    if (srst)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  // --------------------------------------------------------------
  // Channel paths
  // --------------------------------------------------------------
  for (genvar g = 0; g < 8; g++)
  begin : g_chan
    liu_chan_path u_path
    (
      .clk(clk),
      .srst(srst),
      .loop_digital(st.dlb_eff[g]),
      .loop_dual(st.dual_eff[g]),
      .all_ones(st.ones_eff[g]),
      .tx_positive_rail(tx_positive_rail[g]),
      .tx_negative_rail(tx_negative_rail[g]),
      .dec_pos(dec_pos[g]),
      .dec_neg(dec_neg[g]),
      .rx_positive_rail(rx_positive_rail[g]),
      .rx_negative_rail(rx_negative_rail[g]),
      .line_pos(line_pos[g]),
      .line_neg(line_neg[g])
    );
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign host_rdata = st.rdata;
  assign loop_digital = st.dlb_eff;
  assign loop_dual = st.dual_eff;
  assign all_ones = st.ones_eff;
  assign criteria = st.crit_eff;
  assign alarm_on_loss = st.alarm_eff;
  assign protection_disable = st.prot_eff;
  assign ami_select = st.ami_eff;
  assign depth_128 = st.depth_eff;
  assign attenuator_in_rx = st.pos_eff;
  assign attenuator_enable = st.en_eff;
  assign rx_trim_enable = st.trim_eff;
  assign template_select = st.tmpl;
  assign receive_termination_internal = st.rx_int;
  assign monitor_enable = st.mon_en;
  assign monitor_tx = st.mon_tx;
  assign monitor_channel = st.mon_ch;
endmodule // liu_cfg_regs

// *** sim/liu_cfg_regs_chk.sv ***
// Port-level assertions for the configuration bank
`timescale 1ns/1ps
`include "liu_cfg_map.svh"
module liu_cfg_regs_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host port
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  // Side inputs
  input wire logic [7:0] remote_loopback_enable,
  input wire logic [7:0] per_channel_code_select,
  // Effective controls
  input wire logic [7:0] loop_dual,
  input wire logic [7:0] ami_select,
  input wire logic [7:0] alarm_on_loss,
  input wire logic [7:0] protection_disable,
  input wire logic [7:0] depth_128,
  input wire logic [7:0] attenuator_in_rx,
  input wire logic [7:0] attenuator_enable,
  input wire logic receive_termination_internal,
  input wire logic monitor_enable,
  input wire logic monitor_tx,
  input wire logic [2:0] monitor_channel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic gc_wr;
  logic [7:0] wd1;
  logic [7:0] wd2;
  assign gc_wr = host_wr && host_addr == `ADDR_GC;
  // Write data aligned with the edge at which controls settle
  always_ff @(posedge clk)
  begin
    wd1 <= host_wdata;
    wd2 <= wd1;
  end
  ami_force_a : assert property (gc_wr && host_wdata[4] |-> ##2 ami_select == 8'hff)
    else $error("line code not forced");
  ami_follow_a : assert property (gc_wr && !host_wdata[4] |-> ##2 ami_select == $past(per_channel_code_select))
    else $error("line code not per channel");
  alarm_force_a : assert property (gc_wr && host_wdata[6] |-> ##2 alarm_on_loss == 8'hff)
    else $error("alarm on loss not forced");
  prot_force_a : assert property (gc_wr && host_wdata[5] |-> ##2 protection_disable == 8'hff)
    else $error("protection not disabled");
  depth_force_a : assert property (gc_wr && host_wdata[3] |-> ##2 depth_128 == 8'hff)
    else $error("depth not forced");
  pos_force_a : assert property (gc_wr && host_wdata[1] |-> ##2 attenuator_in_rx == 8'hff)
    else $error("position not forced");
  att_force_a : assert property (gc_wr && host_wdata[0] |-> ##2 attenuator_enable == 8'hff)
    else $error("attenuator not forced");
  rx_term_a : assert property (gc_wr |-> ##2 receive_termination_internal == wd2[7])
    else $error("termination mode wrong");
  dual_loop_a : assert property (host_wr && host_addr == `ADDR_DLB |-> ##2 loop_dual == (wd2 & $past(remote_loopback_enable)))
    else $error("dual loopback wrong");
  mon_sel_a : assert property (host_wr && host_addr == `ADDR_MONITOR && host_wdata[2:0] != 3'h0 |-> ##2 monitor_enable && monitor_tx == wd2[3] && monitor_channel == wd2[2:0])
    else $error("monitor selection wrong");
  sel_rsvd_a : assert property (host_rd && host_addr == `ADDR_TSEL |=> host_rdata[7:3] == 5'h00)
    else $error("selector reserved bits set");
endmodule // liu_cfg_regs_chk

// *** sim/liu_cfg_regs_bench.sv ***
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module liu_cfg_regs_bench;
  logic clk = 1'b0, srst = 1'b1, host_wr = 1'b0, host_rd = 1'b0, rti, men, mtx;
  logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, pc = 8'h5a, rl = 8'h00, loss = 8'h00;
  logic [7:0] tp = 8'h00, tn = 8'h00, dp = 8'hf0, dn = 8'h00, host_rdata, rxp, rxn, ldig, ldual, aone;
  logic [7:0] aml, pdis, ami, dep, arx, aen, trim, rd_v, lp, ln;
  logic [2:0] mch;
  liu_cfg_pkg::crit_t [7:0] crit;
  logic [7:0] [7:0] tsel;
  int num_errors = 0, checks = 0, cyc = 0;
  liu_cfg_regs dut (.clk(clk), .srst(srst), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .remote_loopback_enable(rl),
    .per_channel_alarm_on_loss(pc), .per_channel_protection_disable(pc), .per_channel_code_select(pc),
    .per_channel_attenuator_depth(pc), .per_channel_attenuator_position(pc),
    .per_channel_attenuator_enable(pc), .loss_detected(loss), .tx_positive_rail(tp), .tx_negative_rail(tn),
    .dec_pos(dp), .dec_neg(dn), .rx_positive_rail(rxp), .rx_negative_rail(rxn), .line_pos(lp), .line_neg(ln),
    .loop_digital(ldig), .loop_dual(ldual), .all_ones(aone), .criteria(crit), .alarm_on_loss(aml),
    .protection_disable(pdis), .ami_select(ami), .depth_128(dep), .attenuator_in_rx(arx),
    .attenuator_enable(aen), .rx_trim_enable(trim), .template_select(tsel),
    .receive_termination_internal(rti), .monitor_enable(men), .monitor_tx(mtx), .monitor_channel(mch));
  initial forever #4 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) #1;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge clk) #1;
    host_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk) #1;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge clk) #1;
    host_rd = 1'b0;
    rd_v = host_rdata;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_regs();
    logic [7:0] ad[8] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h20};
    logic [7:0] mk[8] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'hfb, 8'h07, 8'hcf, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      rd(ad[i]);
      cmp("reset value", 8'h00, rd_v);
      wr(ad[i], 8'hff);
      rd(ad[i]);
      cmp("read back", mk[i], rd_v);
      wr(ad[i], 8'h00);
    end
    $display("test regs done");
  endtask
  task automatic t_global();
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h0f, 8'h01 << i);
      settle();
      cmp("attenuator enable", i == 0 ? 8'hff : pc, aen);
      cmp("attenuator position", i == 1 ? 8'hff : pc, arx);
      cmp("attenuator depth", i == 3 ? 8'hff : pc, dep);
      cmp("line code", i == 4 ? 8'hff : pc, ami);
      cmp("protection", i == 5 ? 8'hff : pc, pdis);
      cmp("alarm on loss", i == 6 ? 8'hff : pc, aml);
      cmp("rx internal", {7'h00, i == 7}, {7'h00, rti});
    end
    wr(8'h0f, 8'h00);
    $display("test global done");
  endtask
  task automatic t_monitor();
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      wr(8'h0b, {4'h0, c});
      settle();
      if (c[2:0] != 3'h0)
        cmp("monitor", {3'h0, 1'b1, c}, {3'h0, men, mtx, mch});
      else
        cmp("monitor off", 8'h00, {7'h00, men});
    end
    $display("test monitor done");
  endtask
  task automatic t_template();
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h10, 8'(k));
      wr(8'h11, {2'(k), 3'h1, 3'(k)});
    end
    settle();
    for (int k = 0; k < 8; k++)
    begin
      cmp("template", {2'(k), 3'h1, 3'(k)}, tsel[k]);
      wr(8'h10, 8'(k));
      rd(8'h11);
      cmp("template read", {2'(k), 3'h1, 3'(k)}, rd_v);
    end
    // Match-off set on channels 2,3,6,7; channel 0 is E1 at 75 ohm
    cmp("rx trim", 8'h33, trim);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h00);
    settle();
    cmp("rx trim e1 120", 8'h32, trim);
    $display("test template done");
  endtask
  task automatic t_paths();
    logic v;
    wr(8'h0d, 8'hff);
    settle();
    cmp("criteria e1", {6'h00, liu_cfg_pkg::CRIT_ETS}, {6'h00, crit[0]});
    cmp("criteria t1", {6'h00, liu_cfg_pkg::CRIT_T1231}, {6'h00, crit[7]});
    wr(8'h0d, 8'h00);
    settle();
    cmp("criteria g775", {6'h00, liu_cfg_pkg::CRIT_G775}, {6'h00, crit[0]});
    rl = 8'h02;
    tp = 8'h03;
    wr(8'h0c, 8'h03);
    repeat (4) @(posedge clk);
    #1;
    cmp("dual loop", 8'h02, ldual);
    cmp("digital loop", 8'h01, ldig);
    cmp("line pos", 8'h01, lp);
    cmp("rx pos", 8'hf3, rxp);
    cmp("rx neg", 8'h00, rxn);
    loss = 8'h01;
    wr(8'h0e, 8'h01);
    settle();
    cmp("all ones", 8'h01, aone);
    v = lp[0];
    cmp("all ones marks", 8'h01, {7'h00, lp[0] ^ ln[0]});
    @(posedge clk) #1;
    cmp("all ones alternate", {7'h00, ~v}, {7'h00, lp[0]});
    loss = 8'h00;
    settle();
    cmp("all ones off", 8'h00, aone);
    $display("test paths done");
  endtask
  // Hang guard: whole run needs well under this many cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    t_regs();
    t_global();
    t_monitor();
    t_template();
    t_paths();
    end_sim();
  end
endmodule // liu_cfg_regs_bench
bind liu_cfg_regs liu_cfg_regs_chk chk (.clk, .srst, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
  .remote_loopback_enable, .per_channel_code_select, .loop_dual, .ami_select, .alarm_on_loss,
  .protection_disable, .depth_128, .attenuator_in_rx, .attenuator_enable, .receive_termination_internal,
  .monitor_enable, .monitor_tx, .monitor_channel);
